/* File: hw/cvc_pkg.sv */
// package: register map, field layout, reset values and carriers of the comparator block
package cvc_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] CVC_IDX_CMP_CTRL = 8'h19;
    localparam logic [7:0] CVC_IDX_REF_CTRL = 8'h99;
    localparam logic [7:0] CVC_IDX_CHG_FLAG = 8'h0c;
    localparam logic [7:0] CVC_IDX_PIN_DIR = 8'h85;
    localparam logic [7:0] CVC_IDX_PORT_RD = 8'h05;
    localparam logic [11:0] CVC_ADDR_CMP_CTRL = {2'h0, CVC_IDX_CMP_CTRL, 2'h0};
    localparam logic [11:0] CVC_ADDR_REF_CTRL = {2'h0, CVC_IDX_REF_CTRL, 2'h0};
    localparam logic [11:0] CVC_ADDR_CHG_FLAG = {2'h0, CVC_IDX_CHG_FLAG, 2'h0};
    localparam logic [11:0] CVC_ADDR_PIN_DIR = {2'h0, CVC_IDX_PIN_DIR, 2'h0};
    localparam logic [11:0] CVC_ADDR_PORT_RD = {2'h0, CVC_IDX_PORT_RD, 2'h0};

    // comparator control fields
    localparam int CVC_RES_BIT = 6;
    localparam int CVC_INV_BIT = 4;
    localparam int CVC_SWAP_BIT = 3;
    localparam logic [7:0] CVC_CMP_WMASK = 8'h1f;
    localparam logic [7:0] CVC_CMP_RST = 8'h00;

    // reference control fields
    localparam int CVC_REF_ON_BIT = 7;
    localparam int CVC_REF_RNG_BIT = 5;
    localparam logic [7:0] CVC_REF_WMASK = 8'haf;
    localparam logic [7:0] CVC_REF_RST = 8'h00;

    // change flag at bit 3, pin direction six bits set at reset
    localparam int CVC_CHG_BIT = 3;
    localparam logic [7:0] CVC_DIR_WMASK = 8'h3f;
    localparam logic [7:0] CVC_DIR_RST = 8'h3f;
    localparam int CVC_OUT_PIN = 2;

    // modes
    localparam logic [2:0] CVC_MODE_RESET = 3'h0;
    localparam logic [2:0] CVC_MODE_OFF = 3'h7;

    typedef struct packed {
        logic [2:0] mode;
        logic swap;
        logic invert;
    } cvc_cmp_cfg_s;

    typedef struct packed {
        logic power_on;
        logic range_low;
        logic [3:0] level;
    } cvc_ref_cfg_s;

    // mux steering handed to the analog front end
    typedef struct packed {
        logic pos_from_ref;
        logic neg_from_pos_pin;
        logic enable;
        logic drive_pin;
    } cvc_route_s;

endpackage : cvc_pkg

/* File: hw/cvc_mode_dec.sv */
// mode decoder: analog steering, output-pin use and analog-pin map per mode
`timescale 1ns/1ps
module cvc_mode_dec
    import cvc_pkg::*;
(
    // configuration
    input wire cvc_cmp_cfg_s cfg,
    // decoded steering
    output cvc_route_s route,
    output logic [1:0] analog_pins
);
    always_comb begin
        route = '0;
        analog_pins = 2'h3;
        unique case (cfg.mode)
            3'h0: begin
                route.enable = 1'b0;
            end
            3'h1: begin
                route.enable = 1'b1;
                route.drive_pin = 1'b1;
            end
            3'h2: begin
                route.enable = 1'b1;
            end
            3'h3: begin
                route.enable = 1'b1;
                route.pos_from_ref = 1'b1;
                route.drive_pin = 1'b1;
                analog_pins = 2'h2;
            end
            3'h4: begin
                route.enable = 1'b1;
                route.pos_from_ref = 1'b1;
            end
            3'h5: begin
                route.enable = 1'b1;
                route.pos_from_ref = 1'b1;
                route.drive_pin = 1'b1;
                route.neg_from_pos_pin = cfg.swap;
            end
            3'h6: begin
                route.enable = 1'b1;
                route.pos_from_ref = 1'b1;
                route.neg_from_pos_pin = cfg.swap;
            end
            3'h7: begin
                route.enable = 1'b0;
                analog_pins = 2'h0;
            end
        endcase
    end
endmodule : cvc_mode_dec

/* File: hw/cvc_top.sv */
// comparator and voltage reference control with apb register slave
`timescale 1ns/1ps
module cvc_top
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end
    input wire logic cmp_raw,
    output cvc_route_s route,
    output cvc_ref_cfg_s ref_cfg,
    // port pins
    input wire logic [5:0] pin_in,
    output logic cmp_output_pin_oe_n,
    output logic [1:0] analog_pin_map,
    // sleep and wake
    input wire logic sleep,
    output logic cmp_change_flag,
    output logic wake
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] sync_raw;
        logic [5:0] pin_s1;
        logic [5:0] pin_s2;
        cvc_cmp_cfg_s cmp;
        cvc_ref_cfg_s refc;
        logic [5:0] pin_direction;
        logic latched;
        logic flag;
        logic [31:0] rdata;
        logic ready;
        logic err;
        cvc_route_s route;
        logic [1:0] analog;
        logic oe_n;
        logic wake;
    } cvc_state_s;

    cvc_state_s st;
    cvc_state_s next_st;
    cvc_route_s dec_route;
    logic [1:0] dec_analog;

    // all known registers answer without error
    function automatic logic cvc_known(input logic [11:0] a);
        return (a == CVC_ADDR_CMP_CTRL) || (a == CVC_ADDR_REF_CTRL) ||
               (a == CVC_ADDR_CHG_FLAG) || (a == CVC_ADDR_PIN_DIR) ||
               (a == CVC_ADDR_PORT_RD);
    endfunction : cvc_known

    cvc_mode_dec u_dec (
        .cfg(st.cmp),
        .route(dec_route),
        .analog_pins(dec_analog)
    );

    ////////////////////////////////////////////////////////////////////////
    logic cmp_result;
    logic [7:0] cmp_rd;
    logic [7:0] ref_rd;
    logic [7:0] port_rd;
    logic access;
    logic [7:0] wb;
    logic mismatch;

    always_comb begin
        // result from the second sync stage only
        cmp_result = (st.sync_raw[1] & st.route.enable) ^ st.cmp.invert;
        cmp_rd = {1'b0, cmp_result, 1'b0, st.cmp.invert, st.cmp.swap, st.cmp.mode};
        ref_rd = {st.refc.power_on, 1'b0, st.refc.range_low, 1'b0, st.refc.level};
        // pins 0 and 1 read zero while their analog map bit is set
        port_rd = {2'h0, st.pin_s2[5:2], st.pin_s2[1:0] & ~st.analog};
        access = psel & penable & ~st.ready;
        wb = pwdata[7:0];
        mismatch = cmp_result != st.latched;
    end

    always_comb begin
        next_st = st;
        next_st.sync_raw = {st.sync_raw[0], cmp_raw};
        next_st.pin_s1 = pin_in;
        next_st.pin_s2 = st.pin_s1;
        next_st.ready = access;
        next_st.err = access & ~cvc_known(paddr);
        next_st.rdata = 32'h0;
        if (access && !pwrite) begin
            unique case (paddr)
                CVC_ADDR_CMP_CTRL: next_st.rdata = {24'h0, cmp_rd};
                CVC_ADDR_REF_CTRL: next_st.rdata = {24'h0, ref_rd};
                CVC_ADDR_CHG_FLAG: next_st.rdata = {28'h0, st.flag, 3'h0};
                CVC_ADDR_PIN_DIR: next_st.rdata = {26'h0, st.pin_direction};
                CVC_ADDR_PORT_RD: next_st.rdata = {24'h0, port_rd};
                default: next_st.rdata = 32'h0;
            endcase
        end
        // any access of comparator control ends the mismatch
        if (access && paddr == CVC_ADDR_CMP_CTRL) begin
            next_st.latched = cmp_result;
        end
        if (access && pwrite) begin
            unique case (paddr)
                // fields picked by position: struct order differs from the register layout
                CVC_ADDR_CMP_CTRL: begin
                    next_st.cmp.mode = wb[2:0];
                    next_st.cmp.swap = wb[CVC_SWAP_BIT];
                    next_st.cmp.invert = wb[CVC_INV_BIT];
                end
                CVC_ADDR_REF_CTRL: begin
                    next_st.refc.power_on = wb[CVC_REF_ON_BIT];
                    next_st.refc.range_low = wb[CVC_REF_RNG_BIT];
                    next_st.refc.level = wb[3:0];
                end
                CVC_ADDR_CHG_FLAG: next_st.flag = wb[CVC_CHG_BIT];
                CVC_ADDR_PIN_DIR: next_st.pin_direction = wb[5:0] & CVC_DIR_WMASK[5:0];
                default: begin
                end
            endcase
        end
        // hardware set wins over a software clear
        if (mismatch && st.route.enable) begin
            next_st.flag = 1'b1;
        end
        next_st.route = dec_route;
        next_st.analog = dec_analog;
        next_st.oe_n = ~(dec_route.drive_pin & ~st.pin_direction[CVC_OUT_PIN]);
        // sleep does not gate the comparator; wake leaves registers alone
        next_st.wake = sleep & st.flag & st.route.enable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cmp.mode <= CVC_CMP_RST[2:0];
            st.cmp.swap <= CVC_CMP_RST[CVC_SWAP_BIT];
            st.cmp.invert <= CVC_CMP_RST[CVC_INV_BIT];
            st.refc.power_on <= CVC_REF_RST[CVC_REF_ON_BIT];
            st.refc.range_low <= CVC_REF_RST[CVC_REF_RNG_BIT];
            st.refc.level <= CVC_REF_RST[3:0];
            st.pin_direction <= CVC_DIR_RST[5:0];
            st.analog <= 2'h3;
            st.oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign route = st.route;
    assign ref_cfg = st.refc;
    // pin value itself is cmp_raw routed by the pad mux, unclocked; only enable is here
    assign cmp_output_pin_oe_n = st.oe_n;
    assign analog_pin_map = st.analog;
    assign cmp_change_flag = st.flag;
    assign wake = st.wake;
endmodule : cvc_top

/* File: tb/cvc_top_asserts.sv */
// checker: bus timing, read masks, reference writes, flag and wake
`timescale 1ns/1ps
module cvc_chk
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // block side
    input wire cvc_route_s route,
    input wire cvc_ref_cfg_s ref_cfg,
    input wire logic [1:0] analog_pin_map,
    input wire logic sleep,
    input wire logic cmp_change_flag,
    input wire logic wake
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_ok;
    assign rd_ok = pready && !pwrite;
    ////////////////////////////////////////
    chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_cmp_zero_bits: assert property (
        rd_ok && paddr == CVC_ADDR_CMP_CTRL |-> prdata[31:7] == 0 && !prdata[5])
        else $error("cmp ctrl spare bits set");
    chk_ref_zero_bits: assert property (
        rd_ok && paddr == CVC_ADDR_REF_CTRL |-> prdata[31:8] == 0 && !prdata[6] && !prdata[4])
        else $error("ref ctrl spare bits set");
    chk_ref_by_write: assert property (
        $changed(ref_cfg) |-> $past(psel && pwrite && paddr == CVC_ADDR_REF_CTRL))
        else $error("ref cfg changed without write");
    chk_reset_state: assert property (
        $rose(presetn) |-> ref_cfg == '0 && route == '0 && analog_pin_map == 2'h3)
        else $error("bad state after reset");
    chk_flag_hold: assert property (
        cmp_change_flag && !(psel && pwrite && paddr == CVC_ADDR_CHG_FLAG) |=> cmp_change_flag)
        else $error("flag dropped without write");
    chk_wake_cause: assert property (wake |-> $past(sleep) && $past(cmp_change_flag))
        else $error("wake without cause");
    chk_port_analog: assert property (
        rd_ok && paddr == CVC_ADDR_PORT_RD |-> (prdata[1:0] & analog_pin_map) == 2'h0)
        else $error("analog pin reads high");
endmodule : cvc_chk

bind cvc_top cvc_chk i_cvc_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .route(route), .ref_cfg(ref_cfg), .analog_pin_map(analog_pin_map), .sleep(sleep),
    .cmp_change_flag(cmp_change_flag), .wake(wake));

/* File: tb/tb_cvc_top.sv */
// testbench: registers, result, change flag, wake and pin steering
`timescale 1ns/1ps
module tb_cvc_top;
    import cvc_pkg::*;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, raw = '0, sleep = '0;
    logic pready, pslverr, oe_n, flag, wake, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [1:0] amap;
    logic [5:0] pins = 6'h3f;
    cvc_route_s route;
    cvc_ref_cfg_s ref_cfg;
    int err_total = 0, n_checks = 0;
    always #4 pclk = ~pclk;
    cvc_top i_cvc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_raw(raw), .route(route), .ref_cfg(ref_cfg), .pin_in(pins),
        .cmp_output_pin_oe_n(oe_n), .analog_pin_map(amap), .sleep(sleep),
        .cmp_change_flag(flag), .wake(wake));
    ////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= '1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= '1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            err_total++;
            stop_test();
        end
        q = prdata;
        e = pslverr;
        psel <= '0;
        penable <= '0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk("rdata", q, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input int w);
        apb(1'h1, a, d);
        repeat (w) @(posedge pclk);
    endtask : wr
    ////////////////////////////////////////
    task automatic t_regs();
        rd(CVC_ADDR_CMP_CTRL, 32'h0);
        rd(CVC_ADDR_REF_CTRL, 32'h0);
        chk("oe_n", oe_n, 32'h1);
        wr(CVC_ADDR_CMP_CTRL, 32'hff, 3);
        rd(CVC_ADDR_CMP_CTRL, 32'h5f);
        chk("enable", route.enable, 32'h0);
        wr(CVC_ADDR_REF_CTRL, 32'hff, 0);
        rd(CVC_ADDR_REF_CTRL, 32'haf);
        chk("ref_cfg", ref_cfg, 32'h3f);
        wr(CVC_ADDR_REF_CTRL, 32'h25, 2);
        chk("ref_cfg", ref_cfg, 32'h15);
    endtask : t_regs
    task automatic t_result();
        wr(CVC_ADDR_CMP_CTRL, 32'h01, 0);
        raw <= '1;
        repeat (4) @(posedge pclk);
        rd(CVC_ADDR_CMP_CTRL, 32'h41);
        wr(CVC_ADDR_CMP_CTRL, 32'h11, 4);
        rd(CVC_ADDR_CMP_CTRL, 32'h11);
        wr(CVC_ADDR_PIN_DIR, 32'h3b, 2);
        chk("oe_n", oe_n, 32'h0);
        wr(CVC_ADDR_CMP_CTRL, 32'h02, 2);
        chk("oe_n", oe_n, 32'h1);
    endtask : t_result
    task automatic t_flag();
        // a mode change may raise a false change event: latch and clear before relying on it
        wr(CVC_ADDR_CMP_CTRL, 32'h01, 4);
        rd(CVC_ADDR_CMP_CTRL, 32'h41);
        wr(CVC_ADDR_CHG_FLAG, 32'h0, 2);
        chk("flag", flag, 32'h0);
        raw <= '0;
        repeat (5) @(posedge pclk);
        chk("flag", flag, 32'h1);
        wr(CVC_ADDR_CHG_FLAG, 32'h0, 2);
        chk("flag", flag, 32'h1);
        sleep <= '1;
        repeat (3) @(posedge pclk);
        chk("wake", wake, 32'h1);
        rd(CVC_ADDR_CMP_CTRL, 32'h01);
        wr(CVC_ADDR_CHG_FLAG, 32'h0, 2);
        chk("flag", flag, 32'h0);
        chk("wake", wake, 32'h0);
        sleep <= '0;
    endtask : t_flag
    task automatic t_route();
        rd(12'h000, 32'h0);
        chk("pslverr", e, 32'h1);
        wr(CVC_ADDR_CMP_CTRL, 32'h0e, 2);
        chk("route", route, 32'he);
        wr(CVC_ADDR_CMP_CTRL, 32'h0a, 2);
        chk("route", route, 32'h2);
        wr(CVC_ADDR_CMP_CTRL, 32'h05, 2);
        chk("route", route, 32'hb);
        wr(CVC_ADDR_CMP_CTRL, 32'h0b, 2);
        chk("route", route, 32'hb);
        wr(CVC_ADDR_CMP_CTRL, 32'h0c, 2);
        chk("route", route, 32'ha);
        wr(CVC_ADDR_CMP_CTRL, 32'h00, 2);
        rd(CVC_ADDR_PORT_RD, 32'h3c);
        pins <= 6'h2a;
        wr(CVC_ADDR_CMP_CTRL, 32'h00, 2);
        chk("amap", amap, 32'h3);
        rd(CVC_ADDR_PORT_RD, 32'h28);
    endtask : t_route
    // reset in mid-run with non-default settings in place
    task automatic t_reset();
        wr(CVC_ADDR_CMP_CTRL, 32'h13, 2);
        presetn <= '0;
        repeat (3) @(posedge pclk);
        presetn <= '1;
        rd(CVC_ADDR_CMP_CTRL, 32'h0);
        rd(CVC_ADDR_REF_CTRL, 32'h0);
        chk("ref_cfg", ref_cfg, 32'h0);
        chk("amap", amap, 32'h3);
        chk("oe_n", oe_n, 32'h1);
        chk("flag", flag, 32'h0);
    endtask : t_reset
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= '1;
        t_regs();
        t_result();
        t_flag();
        t_route();
        t_reset();
        stop_test();
    end
endmodule : tb_cvc_top
